// ---- src/flash_write_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
// Counts oscillator ticks for one flash write; ignores reset while busy.
module flash_write_timer #(
  parameter int unsigned TICKS = fuse_rb_pkg::WRITE_TICKS
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_rc_tick,
  input wire logic i_start,
  output logic o_busy
);
  import fuse_rb_pkg::*;
  // Power-up value: reset cannot clear a timer that is still busy, so the
  // first reset would otherwise meet an unknown busy bit and never leave it.
  logic busy = 1'b0;
  logic next_busy;
  logic [15:0] count = 16'h0000;
  logic [15:0] next_count;

  // Reset only clears an idle timer, so a write in flight always finishes.
  always_comb begin
    next_busy = busy;
    next_count = count;
    if (!busy) begin
      if (i_start && i_nrst) begin
        next_busy = 1'b1;
        next_count = TICK_RESET;
      end
    end else if (i_rc_tick) begin
      if (count == 16'(TICKS - 1)) begin
        next_busy = 1'b0;
      end else begin
        next_count = count + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst && !busy) begin
      busy <= 1'b0;
      count <= TICK_RESET;
    end else begin
      busy <= next_busy;
      count <= next_count;
    end
  end

  assign o_busy = busy;

  chk_busy_holds_reset: assert property (@(posedge i_clk)
    busy && !i_rc_tick |=> busy) else $error("write ended without a tick");
  cov_write_run: cover property (@(posedge i_clk) $fell(busy));
endmodule
`default_nettype wire

// ---- src/fuse_lock_readback.sv ----
`timescale 1ns/10ps
`default_nettype none
module fuse_lock_readback (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_rc_tick,
  input wire logic i_sleep_power_down,
  input wire logic i_eeprom_program_enable_flag,
  input wire logic i_ctrl_write,
  input wire logic i_lock_bit_access_select,
  input wire logic i_self_program_enable,
  input wire logic i_page_erase_cmd,
  input wire logic i_page_write_cmd,
  input wire logic i_concurrent_read_reenable_cmd,
  input wire logic i_store_instr,
  input wire logic i_load_instr,
  input wire logic [15:0] i_z,
  input wire logic [7:0] i_flash_byte,
  input wire logic [15:0] i_fetch_addr,
  input wire logic [15:0] i_boot_start,
  input wire logic [7:0] i_fuse_low_cells,
  input wire logic [7:0] i_fuse_high_cells,
  input wire logic [7:0] i_extended_fuse_cells,
  input wire logic [7:0] i_lock_cells,
  output logic [7:0] o_destination_register,
  output logic o_load_done,
  output logic o_lock_bit_access_select,
  output logic o_self_program_enable,
  output logic o_concurrent_read_busy_flag,
  output logic o_write_busy,
  output logic o_fetch_blocked
);
  import fuse_rb_pkg::*;

  logic sel;
  logic spe;
  logic [2:0] age;
  logic [7:0] dest;
  logic done;
  logic rww_busy;
  logic blocked;
  logic next_sel;
  logic next_spe;
  logic [2:0] next_age;
  logic [7:0] next_dest;
  logic next_done;
  logic next_rww_busy;
  logic next_blocked;
  logic write_start;
  logic write_busy;
  logic ctrl_ok;
  logic readback_armed;

  // Cells store a programmed bit as a cleared cell, so no inversion is needed.
  function automatic logic [7:0] config_byte(input logic [15:0] z);
    unique case (z)
      Z_FUSE_LOW: config_byte = i_fuse_low_cells;
      Z_LOCK: config_byte = i_lock_cells;
      Z_FUSE_EXT: config_byte = i_extended_fuse_cells;
      Z_FUSE_HIGH: config_byte = i_fuse_high_cells;
      default: config_byte = BYTE_RESET;
    endcase
  endfunction

  // Writes are refused asleep and during EEPROM writes.
  assign ctrl_ok = i_ctrl_write && !i_sleep_power_down && !i_eeprom_program_enable_flag;
  assign readback_armed = sel && spe && (age < LOAD_WINDOW) && !i_eeprom_program_enable_flag;
  assign write_start = spe && !sel && (age < STORE_WINDOW) && i_store_instr
    && (i_page_erase_cmd || i_page_write_cmd) && !write_busy;

  // Enable bits, window age, readback data and section busy state.
  always_comb begin
    next_sel = sel;
    next_spe = spe;
    next_age = age;
    next_dest = dest;
    next_done = 1'b0;
    next_rww_busy = rww_busy;
    next_blocked = write_busy;
    if (sel || spe) begin
      next_age = (age == 3'h7) ? age : age + 3'h1;
    end
    if (readback_armed && i_load_instr) begin
      next_dest = config_byte(i_z);
      next_done = 1'b1;
      next_sel = 1'b0;
      next_spe = 1'b0;
    end else if (i_load_instr) begin
      next_dest = i_flash_byte;
      next_done = 1'b1;
    end
    // Timeouts only drop the enables; cells are never touched.
    if (sel && spe && age >= LOAD_WINDOW - 3'h1) begin
      next_sel = 1'b0;
      next_spe = 1'b0;
    end
    if (spe && !sel && (age >= STORE_WINDOW - 3'h1 || i_store_instr)) begin
      next_spe = 1'b0;
    end
    if (write_start) begin
      next_rww_busy = 1'b1;
    end
    if (!write_busy && spe && i_store_instr && i_concurrent_read_reenable_cmd) begin
      next_rww_busy = 1'b0;
    end
    if (ctrl_ok) begin
      next_sel = i_lock_bit_access_select;
      next_spe = i_self_program_enable;
      next_age = 3'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sel <= 1'b0;
      spe <= 1'b0;
      age <= 3'h0;
      dest <= 8'h00;
      done <= 1'b0;
      // A write survives reset, so its busy indications must survive too.
      rww_busy <= write_busy;
      blocked <= write_busy;
    end else begin
      sel <= next_sel;
      spe <= next_spe;
      age <= next_age;
      dest <= next_dest;
      done <= next_done;
      rww_busy <= next_rww_busy;
      blocked <= next_blocked;
    end
  end

  flash_write_timer u_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_rc_tick(i_rc_tick),
    .i_start(write_start),
    .o_busy(write_busy)
  );

  // Fetch blocking compares against the boot start; registered for timing.
  logic fetch_blk;
  logic next_fetch_blk;
  always_comb begin
    next_fetch_blk = write_busy && (i_fetch_addr < i_boot_start);
  end
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      fetch_blk <= 1'b0;
    end else begin
      fetch_blk <= next_fetch_blk;
    end
  end

  assign o_destination_register = dest;
  assign o_load_done = done;
  assign o_lock_bit_access_select = sel;
  assign o_self_program_enable = spe;
  assign o_concurrent_read_busy_flag = rww_busy;
  assign o_write_busy = blocked;
  assign o_fetch_blocked = fetch_blk;

  chk_enables_expire: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(sel && spe) && !i_ctrl_write [*1] ##1 !i_ctrl_write [*3] |-> !(sel && spe))
    else $error("enables outlived load window");
  chk_readback_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
    readback_armed && i_load_instr && i_z == Z_FUSE_LOW |=> dest == $past(i_fuse_low_cells))
    else $error("fuse low byte wrong");
  chk_readback_high: assert property (@(posedge i_clk) disable iff (!i_nrst)
    readback_armed && i_load_instr && i_z == Z_FUSE_HIGH |=> dest == $past(i_fuse_high_cells))
    else $error("fuse high byte wrong");
  chk_readback_ext: assert property (@(posedge i_clk) disable iff (!i_nrst)
    readback_armed && i_load_instr && i_z == Z_FUSE_EXT |=> dest == $past(i_extended_fuse_cells))
    else $error("extended fuse byte wrong");
  chk_plain_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !sel && !spe && i_load_instr |=> dest == $past(i_flash_byte) && done)
    else $error("plain load substituted");
  chk_clear_after_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
    readback_armed && i_load_instr && !ctrl_ok |=> !sel && !spe)
    else $error("enables stayed after readback");
  chk_sleep_no_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_sleep_power_down && !sel && !spe |=> !sel && !spe)
    else $error("control written in sleep");
  chk_eeprom_blocks: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_eeprom_program_enable_flag && i_load_instr |=> dest == $past(i_flash_byte))
    else $error("readback during eeprom write");
  chk_busy_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
    write_busy |-> ##1 rww_busy) else $error("busy flag low during write");
  chk_fetch_block: assert property (@(posedge i_clk) disable iff (!i_nrst)
    write_busy && i_fetch_addr < i_boot_start |=> fetch_blk)
    else $error("fetch not blocked");


  // Readback of the remaining address and of an unknown address in the window.
  chk_readback_lock: assert property (@(posedge i_clk) disable iff (!i_nrst)
    readback_armed && i_load_instr && i_z == Z_LOCK |=> dest == $past(i_lock_cells))
    else $error("lock byte wrong");

  chk_readback_other: assert property (@(posedge i_clk) disable iff (!i_nrst)
    readback_armed && i_load_instr && i_z > Z_FUSE_HIGH |=> dest == BYTE_RESET)
    else $error("unknown address not all ones");

  chk_plain_outside: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !readback_armed && i_load_instr |=> dest == $past(i_flash_byte))
    else $error("flash byte replaced outside window");

  // Load handshake: the done pulse follows every load and nothing else.
  chk_done_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_load_instr |=> done)
    else $error("load without done");

  chk_done_only_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_load_instr |=> !done)
    else $error("done without load");

  chk_dest_holds: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_load_instr |=> dest == $past(dest))
    else $error("destination changed without load");

  // Control register writes and their refusal.
  chk_ctrl_takes: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ctrl_ok |=> sel == $past(i_lock_bit_access_select) && age == 3'h0)
    else $error("control write not taken");

  chk_ctrl_takes_spe: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ctrl_ok |=> spe == $past(i_self_program_enable))
    else $error("enable bit not taken");

  chk_eeprom_refused: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_eeprom_program_enable_flag && !sel && !spe |=> !sel && !spe)
    else $error("control written during eeprom write");

  chk_no_stray_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !ctrl_ok && !sel |=> !sel)
    else $error("select set without a write");

  chk_no_stray_spe: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !ctrl_ok && !spe |=> !spe)
    else $error("enable set without a write");

  // Window expiry of both enable forms; a new write restarts the window.
  chk_pair_window: assert property (@(posedge i_clk) disable iff (!i_nrst)
    sel && spe && age >= 3'h2 && !ctrl_ok |=> !sel && !spe)
    else $error("enables outlived three cycles");

  chk_spe_window: assert property (@(posedge i_clk) disable iff (!i_nrst)
    spe && !sel && age >= 3'h3 && !ctrl_ok |=> !spe)
    else $error("enable outlived four cycles");

  chk_spe_store_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    spe && !sel && i_store_instr && !ctrl_ok |=> !spe)
    else $error("enable stayed after store");

  chk_age_saturates: assert property (@(posedge i_clk) disable iff (!i_nrst)
    age == 3'h7 && !ctrl_ok |=> age == 3'h7)
    else $error("window age wrapped");

  // Write timing, busy indications and fetch blocking.
  chk_write_starts: assert property (@(posedge i_clk) disable iff (!i_nrst)
    write_start |=> write_busy)
    else $error("write did not start");

  chk_busy_out: assert property (@(posedge i_clk) disable iff (!i_nrst)
    1'b1 |=> blocked == $past(write_busy))
    else $error("busy output lost the timer");

  chk_rww_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
    write_start |=> rww_busy)
    else $error("busy flag not set by write");

  chk_rww_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    rww_busy && write_busy |=> rww_busy)
    else $error("busy flag cleared during write");

  chk_fetch_free: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !write_busy |=> !fetch_blk)
    else $error("fetch blocked while idle");

  chk_fetch_boot: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_fetch_addr >= i_boot_start |=> !fetch_blk)
    else $error("boot fetch blocked");

  // Sleep refuses a control write even when the select bit is requested.
  chk_sleep_refused: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_ctrl_write && i_sleep_power_down && !sel |=> !sel)
    else $error("select written in sleep");

  // Main scenarios that the bench is expected to reach.
  cov_fuse_read: cover property (@(posedge i_clk) readback_armed && i_load_instr);
  cov_timeout: cover property (@(posedge i_clk) $fell(sel) && !done);
  cov_write: cover property (@(posedge i_clk) write_start);
endmodule
`default_nettype wire

// ---- src/fuse_rb_pkg.sv ----
package fuse_rb_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  // Address values on the Z pointer that select a configuration byte.
  localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
  localparam logic [15:0] Z_LOCK = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  // Window lengths in CPU cycles after the enable bits are set.
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  // Flash write time, in microseconds, timed from the RC oscillator.
  localparam int unsigned WRITE_MIN_US = 3700;
  localparam int unsigned WRITE_MAX_US = 4500;
  localparam int unsigned RC_HZ = 8000000;
  // Both tick counts are plain products; the least time adds no round-up term.
  localparam int unsigned WRITE_MIN_TICKS = (WRITE_MIN_US * (RC_HZ / 1000000) + 0) ;
  localparam int unsigned WRITE_MAX_TICKS = WRITE_MAX_US * (RC_HZ / 1000000);
  localparam int unsigned WRITE_TICKS = WRITE_MIN_TICKS + 1;
  localparam logic [7:0] BYTE_RESET = 8'hff;
  localparam logic [15:0] TICK_RESET = 16'h0000;
  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_WRITE, OP_LOCK} flash_op_t;
endpackage

// ---- tb/flash_side_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Stands in for the configuration cells, the flash array and the RC oscillator.
module flash_side_model (
  input wire logic i_clk,
  input wire logic i_fast,
  input wire logic [15:0] i_z,
  output logic [7:0] o_low,
  output logic [7:0] o_high,
  output logic [7:0] o_ext,
  output logic [7:0] o_lock,
  output logic [7:0] o_flash,
  output logic o_rc_tick
);
  logic [2:0] div = 3'h0;
  // Cells read zero where programmed; mixed patterns expose any bit reordering.
  assign o_low = 8'ha5;
  assign o_high = 8'hdf;
  assign o_ext = 8'hf9;
  // Boot lock bits programmed, as software with fixed boot code should leave them.
  assign o_lock = 8'hcc;
  assign o_flash = i_z[7:0] ^ 8'h3c;
  // Five CPU cycles per RC period; fast mode ticks every cycle so a write fits the run.
  always @(posedge i_clk) div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
  assign o_rc_tick = i_fast | (div == 3'h0);
endmodule
`default_nettype wire

// ---- tb/fuse_lock_readback_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module fuse_lock_readback_bench;
  import fuse_rb_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, fast = 1'b0, slp = 1'b0, ee = 1'b0, cw = 1'b0;
  logic sel = 1'b0, spe = 1'b0, ers = 1'b0, wr = 1'b0, ren = 1'b0, st = 1'b0, ld = 1'b0;
  logic [15:0] z = 16'h0000, fa = 16'h0000, bs = 16'h1c00;
  logic [7:0] fuse_low_byte, fuse_high_byte, efb, lkb, fb, dest;
  logic rc, done, osel, ospe, rwwb, wbusy, fblk;
  int err_count = 0, checks = 0;
  always #12.5 clk = ~clk;
  fuse_lock_readback uut (.i_clk(clk), .i_nrst(nrst), .i_rc_tick(rc),
    .i_sleep_power_down(slp), .i_eeprom_program_enable_flag(ee), .i_ctrl_write(cw),
    .i_lock_bit_access_select(sel), .i_self_program_enable(spe), .i_page_erase_cmd(ers),
    .i_page_write_cmd(wr), .i_concurrent_read_reenable_cmd(ren), .i_store_instr(st),
    .i_load_instr(ld), .i_z(z), .i_flash_byte(fb), .i_fetch_addr(fa), .i_boot_start(bs),
    .i_fuse_low_cells(fuse_low_byte), .i_fuse_high_cells(fuse_high_byte), .i_extended_fuse_cells(efb),
    .i_lock_cells(lkb), .o_destination_register(dest), .o_load_done(done),
    .o_lock_bit_access_select(osel), .o_self_program_enable(ospe),
    .o_concurrent_read_busy_flag(rwwb), .o_write_busy(wbusy), .o_fetch_blocked(fblk));
  flash_side_model far (.i_clk(clk), .i_fast(fast), .i_z(z), .o_low(fuse_low_byte), .o_high(fuse_high_byte),
    .o_ext(efb), .o_lock(lkb), .o_flash(fb), .o_rc_tick(rc));
  // One comparison helper; flags are widened to a byte.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Control register write, one cycle wide, launched from a falling edge.
  task ctrl(input logic s, input logic p);
    @(negedge clk);
    cw = 1'b1;
    sel = s;
    spe = p;
    @(negedge clk);
    cw = 1'b0;
    sel = 1'b0;
    spe = 1'b0;
  endtask
  // Load issued d cycles after the write edge; result is settled one falling edge later.
  task load(input int d, input logic [15:0] a);
    repeat (d) @(negedge clk);
    z = a;
    ld = 1'b1;
    @(negedge clk);
    ld = 0;
  endtask
  task t_fuses;
    logic [15:0] za [4];
    logic [7:0] ex [4];
    za = '{Z_FUSE_LOW, Z_LOCK, Z_FUSE_EXT, Z_FUSE_HIGH};
    ex = '{8'ha5, 8'hcc, 8'hf9, 8'hdf};
    for (int i = 0; i < 4; i++) begin
      ctrl(1'b1, 1'b1);
      load(i % 3, za[i]);
      chk("config byte", ex[i], dest);
      chk("load done", 8'h01, {7'h0, done});
      chk("enables after read", 8'h00, {6'h0, osel, ospe});
    end
    $display("test fuses finished");
  endtask
  // A load one cycle too late must see plain flash and leave nothing behind.
  task t_late;
    ctrl(1'b1, 1'b1);
    chk("enables set", 8'h03, {6'h0, osel, ospe});
    load(3, Z_LOCK);
    chk("late load byte", 8'h3d, dest);
    chk("enables expired", 8'h00, {6'h0, osel, ospe});
    ctrl(1'b0, 1'b1);
    repeat (5) @(negedge clk);
    chk("store window expired", 8'h00, {7'h0, ospe});
    $display("test late finished");
  endtask
  // Sleep and a running EEPROM write both refuse the control write.
  task t_block;
    slp = 1'b1;
    ctrl(1'b1, 1'b1);
    chk("write in sleep", 8'h00, {6'h0, osel, ospe});
    slp = 1'b0;
    ee = 1'b1;
    ctrl(1'b1, 1'b1);
    load(0, Z_FUSE_LOW);
    chk("read in eeprom write", 8'h3c, dest);
    ee = 1'b0;
    $display("test block finished");
  endtask
  // Page erase with a reset in mid-write; length is measured in RC ticks.
  task t_write;
    time t0;
    fast = 1'b1;
    ctrl(1'b0, 1'b1);
    st = 1'b1;
    ers = 1'b1;
    t0 = $time;
    @(negedge clk);
    st = 1'b0;
    ers = 1'b0;
    repeat (2) @(negedge clk);
    chk("write busy", 8'h03, {6'h0, wbusy, rwwb});
    fa = 16'h0100;
    @(negedge clk);
    chk("fetch outside boot", 8'h01, {7'h0, fblk});
    fa = 16'h1c10;
    @(negedge clk);
    chk("fetch in boot", 8'h00, {7'h0, fblk});
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chk("busy through reset", 8'h01, {7'h0, wbusy});
    while (wbusy === 1'b1 && $time - t0 < 25 * (WRITE_MAX_TICKS + 20)) @(negedge clk);
    t0 = ($time - t0) / 25;
    chk("write length", 8'h01, {7'h0, t0 >= WRITE_MIN_TICKS && t0 <= WRITE_MAX_TICKS});
    ctrl(1'b0, 1'b1);
    st = 1'b1;
    ren = 1'b1;
    @(negedge clk);
    st = 1'b0;
    ren = 1'b0;
    @(negedge clk);
    chk("busy flag cleared", 8'h00, {7'h0, rwwb});
    fast = 1'b0;
    $display("test write finished");
  endtask
  // Main sequence after two cycles of reset.
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_fuses;
    t_late;
    t_block;
    t_write;
    final_report;
  end
  // Watchdog sized for one shortened write plus margin.
  initial begin
    #1000000;
    err_count++;
    final_report;
  end
endmodule
`default_nettype wire
